// file: design/uwf_core.sv
// flags, wakeup, nine-bit data and line routing of the serial interface
`timescale 1ns/1ps
`include "uwf_params.svh"
module uwf_core (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // register port
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // power state
    input wire logic stop_i,
    input wire logic stop_deep_i,
    // receiver shifter side
    input wire logic rx_done_i,
    input wire uwf_pkg::uwf_rxc_t rx_char_i,
    input wire logic rx_msb_i,
    input wire logic rx_bit_tick_i,
    input wire logic rx_level_i,
    output logic rx_serial_o,
    // transmitter shifter side
    input wire logic tx_load_i,
    input wire logic tx_busy_i,
    input wire logic tx_serial_i,
    output logic tx_req_o,
    output logic [8:0] tx_data_o,
    // pins
    input wire logic rxd_i,
    input wire logic txd_i,
    output logic txd_o,
    output logic txd_oe_o,
    output logic rxd_used_o,
    // interrupt requests
    output logic irq_tx_o,
    output logic irq_rx_o,
    output logic irq_err_o
);
    import uwf_pkg::*;

    logic [7:0] c1_r;
    logic [7:0] c2_r;
    logic [5:0] c3_r;
    logic t9_r;
    logic r9_r;
    logic [7:0] rxd_r;
    logic [7:0] txb_r;
    uwf_stat_t st_r;
    logic arm_r;
    logic drd_r;
    logic c3rd_r;
    logic idle_ok_r;
    logic [3:0] icnt_r;
    logic run;
    logic deep;
    logic nine;
    logic rd_s1;
    logic rd_d;
    logic rd_c3;
    logic clr;
    logic wake_idle;
    logic wake_adr;
    logic awake;
    logic xfer;
    logic ovr_set;
    logic idle_hit;
    logic [3:0] ilim;
    logic [7:0] c2_w;

    // light stop freezes state; deep stop returns to reset values
    assign run = ~stop_i;
    assign deep = stop_deep_i;
    assign nine = c1_r[`UWF_B_NINE];
    assign rd_s1 = run & rd_i & (addr_i == `UWF_A_S1);
    assign rd_d = run & rd_i & (addr_i == `UWF_A_D);
    assign rd_c3 = run & rd_i & (addr_i == `UWF_A_C3);
    assign c2_w = (run & wr_i & (addr_i == `UWF_A_C2)) ? wdata_i : 8'h00;

    // clear completes at the later of data read and ninth-bit read
    assign clr = arm_r & (rd_d | drd_r)
        & (~nine | rd_c3 | c3rd_r) & (rd_d | (nine & rd_c3));

    // character completion: address msb wakes before the stop bit
    assign wake_adr = c1_r[`UWF_B_WAKE] & rx_msb_i;
    assign awake = ~c2_r[`UWF_B_SLEEP]
        | (c1_r[`UWF_B_WAKE] & rx_char_i.data[nine ? 8 : 7]);
    assign xfer = run & rx_done_i & awake & ~st_r.fe
        & (~st_r.rx_buffer_full_flag | clr);
    assign ovr_set = run & rx_done_i & awake & ~st_r.fe
        & st_r.rx_buffer_full_flag & ~clr;

    // idle counting on bit ticks
    assign ilim = nine ? `UWF_IDLE9 : `UWF_IDLE8;
    assign idle_hit = run & rx_bit_tick_i & rx_level_i
        & (icnt_r == ilim - 4'h1);
    assign wake_idle = idle_hit & ~c1_r[`UWF_B_WAKE];

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            icnt_r <= 4'h0;
        end else if (deep) begin
            icnt_r <= 4'h0;
        end else if (run) begin
            // with the later start the stop bit is excluded from the count
            if (rx_done_i & c1_r[`UWF_B_ILT]) begin
                icnt_r <= 4'h0;
            end else if (rx_bit_tick_i) begin
                if (!rx_level_i) begin
                    icnt_r <= 4'h0;
                end else if (icnt_r != ilim) begin
                    icnt_r <= icnt_r + 4'h1;
                end
            end
        end
    end

    // control registers
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            c1_r <= `UWF_RST_C;
            c3_r <= 6'h00;
            t9_r <= 1'b0;
        end else if (deep) begin
            c1_r <= `UWF_RST_C;
            c3_r <= 6'h00;
            t9_r <= 1'b0;
        end else if (run & wr_i) begin
            if (addr_i == `UWF_A_C1) begin
                c1_r <= wdata_i;
            end
            if (addr_i == `UWF_A_C3) begin
                c3_r <= wdata_i[5:0];
                t9_r <= wdata_i[`UWF_B_T9];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            c2_r <= `UWF_RST_C;
        end else if (deep) begin
            c2_r <= `UWF_RST_C;
        end else if (run) begin
            if (wr_i & (addr_i == `UWF_A_C2)) begin
                c2_r <= wdata_i;
            end
            // a software write of sleep overrides a same-cycle wakeup
            if (~c2_w[`UWF_B_SLEEP] & (wake_idle | wake_adr)) begin
                c2_r[`UWF_B_SLEEP] <= 1'b0;
            end
        end
    end

    // receive buffer with ninth bit
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rxd_r <= 8'h00;
            r9_r <= 1'b0;
        end else if (deep) begin
            rxd_r <= 8'h00;
            r9_r <= 1'b0;
        end else if (xfer) begin
            rxd_r <= rx_char_i.data[7:0];
            r9_r <= rx_char_i.data[8];
        end
    end

    // clear sequence tracking
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            arm_r <= 1'b0;
            drd_r <= 1'b0;
            c3rd_r <= 1'b0;
        end else if (deep | clr) begin
            arm_r <= 1'b0;
            drd_r <= 1'b0;
            c3rd_r <= 1'b0;
        end else if (rd_s1) begin
            arm_r <= st_r.rx_buffer_full_flag | st_r.idle;
            drd_r <= 1'b0;
            c3rd_r <= 1'b0;
        end else if (arm_r) begin
            drd_r <= drd_r | rd_d;
            c3rd_r <= c3rd_r | rd_c3;
        end
    end

    // receive flags; a same-cycle set beats the clear
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r.tx_buffer_empty_flag <= 1'b1;
            st_r.tc <= 1'b1;
            st_r.rx_buffer_full_flag <= 1'b0;
            st_r.idle <= 1'b0;
            st_r.ovr <= 1'b0;
            st_r.nf <= 1'b0;
            st_r.fe <= 1'b0;
            st_r.pf <= 1'b0;
            idle_ok_r <= 1'b0;
        end else if (deep) begin
            st_r.tx_buffer_empty_flag <= 1'b1;
            st_r.tc <= 1'b1;
            st_r.rx_buffer_full_flag <= 1'b0;
            st_r.idle <= 1'b0;
            st_r.ovr <= 1'b0;
            st_r.nf <= 1'b0;
            st_r.fe <= 1'b0;
            st_r.pf <= 1'b0;
            idle_ok_r <= 1'b0;
        end else if (run) begin
            // all status bits share one process so the word has one driver
            if (tx_load_i) begin
                st_r.tx_buffer_empty_flag <= 1'b1;
            end else if (wr_i & (addr_i == `UWF_A_D)) begin
                st_r.tx_buffer_empty_flag <= 1'b0;
            end
            st_r.tc <= st_r.tx_buffer_empty_flag & ~tx_busy_i & ~tx_load_i;
            if (xfer) begin
                st_r.rx_buffer_full_flag <= 1'b1;
                st_r.nf <= rx_char_i.noise;
                st_r.fe <= rx_char_i.frame;
                st_r.pf <= rx_char_i.parity;
                idle_ok_r <= 1'b1;
            end else if (clr) begin
                st_r.rx_buffer_full_flag <= 1'b0;
                st_r.nf <= 1'b0;
                st_r.fe <= 1'b0;
                st_r.pf <= 1'b0;
            end
            if (ovr_set) begin
                st_r.ovr <= 1'b1;
            end else if (clr) begin
                st_r.ovr <= 1'b0;
            end
            // sleeping idle only wakes; idle flag needs a fresh character
            if (idle_hit & ~c2_r[`UWF_B_SLEEP] & idle_ok_r) begin
                st_r.idle <= 1'b1;
                idle_ok_r <= 1'b0;
            end else if (clr) begin
                st_r.idle <= 1'b0;
            end
        end
    end

    // transmit buffer; a load in the same cycle as a data write wins
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            txb_r <= 8'h00;
            tx_data_o <= 9'h000;
        end else if (deep) begin
            txb_r <= 8'h00;
            tx_data_o <= 9'h000;
        end else if (run) begin
            if (tx_load_i) begin
                tx_data_o <= {t9_r, txb_r};
            end else if (wr_i & (addr_i == `UWF_A_D)) begin
                txb_r <= wdata_i;
            end
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (deep) begin
            rdata_o <= 8'h00;
        end else if (run & rd_i) begin
            case (addr_i)
                `UWF_A_C1: rdata_o <= c1_r;
                `UWF_A_C2: rdata_o <= c2_r;
                `UWF_A_S1: rdata_o <= st_r;
                `UWF_A_C3: rdata_o <= {r9_r, t9_r, c3_r};
                `UWF_A_D: rdata_o <= rxd_r;
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // interrupt requests
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_tx_o <= 1'b0;
            irq_rx_o <= 1'b0;
            irq_err_o <= 1'b0;
        end else begin
            irq_tx_o <= (c2_r[`UWF_B_TIE] & st_r.tx_buffer_empty_flag)
                | (c2_r[`UWF_B_TX_DONE_IRQ_ENABLE] & st_r.tc);
            irq_rx_o <= (c2_r[`UWF_B_RIE] & st_r.rx_buffer_full_flag)
                | (c2_r[`UWF_B_ILIE] & st_r.idle);
            irq_err_o <= (c3_r[`UWF_B_ORIE] & st_r.ovr)
                | (c3_r[`UWF_B_NEIE] & st_r.nf)
                | (c3_r[`UWF_B_FEIE] & st_r.fe)
                | (c3_r[`UWF_B_PEIE] & st_r.pf);
        end
    end

    // line routing, registered so every pin leaves a flip-flop
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_serial_o <= 1'b1;
            txd_o <= 1'b1;
            txd_oe_o <= 1'b1;
            rxd_used_o <= 1'b1;
            tx_req_o <= 1'b0;
        end else begin
            tx_req_o <= ~st_r.tx_buffer_empty_flag;
            txd_o <= tx_serial_i;
            rxd_used_o <= ~c1_r[`UWF_B_ROUTE];
            if (!c1_r[`UWF_B_ROUTE]) begin
                rx_serial_o <= rxd_i;
                txd_oe_o <= 1'b1;
            end else if (!c1_r[`UWF_B_RECEIVER_SOURCE_SELECT]) begin
                rx_serial_o <= tx_serial_i;
                txd_oe_o <= 1'b1;
            end else if (c3_r[`UWF_B_DIR]) begin
                rx_serial_o <= tx_serial_i;
                txd_oe_o <= 1'b1;
            end else begin
                rx_serial_o <= txd_i;
                txd_oe_o <= 1'b0;
            end
        end
    end
endmodule // uwf_core

// file: design/uwf_params.svh
// offsets, field positions, reset values and counts of the wakeup/flag block
// Contract
// - receiver sleep suppresses every receive status flag for incoming characters.
// - idle wakeup clears sleep after 10 idle bits, 11 in nine-bit mode.
// - the waking idle character sets neither idle nor buffer-full flag.
// - idle select 0 counts from start bit; 1 counts after stop bit.
// - address-mark wakeup clears sleep when the received msb is 1.
// - address frame clears sleep before its stop bit and sets buffer-full.
// - three requests from eight sources, each masked, flags always pollable.
// - transmit request stands while buffer-empty flag and its enable are 1.
// - transmit-done flag when all sent and line idle; request while enabled.
// - buffer-full clears on status read then data read; nine-bit adds control three.
// - idle flag clears likewise and rearms only after a new buffer-full.
// - noise, framing, parity flags set together with buffer-full, never on overrun.
// - full buffer at completion sets overrun and discards character and errors.
// - nine-bit select gives nine data bits, ninth bits in control three.
// - ninth transmit bit copied at shifter load and held until rewritten.
// - stop halts the clock; deep stop loses registers, light stop keeps them.
// - route on, source 0: transmitter feeds receiver, input pin released.
// - route on, source 1: single wire joins receiver, transmitter and output pin.
// - single-wire direction 0 makes pin an input; 1 lets transmitter drive.
// - completed character enters an empty buffer and sets buffer-full.
// - while framing flag stands no character transfers into the buffer.
`ifndef UWF_PARAMS_SVH
`define UWF_PARAMS_SVH
`define UWF_A_C1 3'h0
`define UWF_A_C2 3'h1
`define UWF_A_S1 3'h2
`define UWF_A_C3 3'h3
`define UWF_A_D 3'h4
// control one
`define UWF_B_ROUTE 7
`define UWF_B_RECEIVER_SOURCE_SELECT 5
`define UWF_B_NINE 4
`define UWF_B_WAKE 3
`define UWF_B_ILT 2
// control two
`define UWF_B_TIE 7
`define UWF_B_TX_DONE_IRQ_ENABLE 6
`define UWF_B_RIE 5
`define UWF_B_ILIE 4
`define UWF_B_SLEEP 1
// control three
`define UWF_B_R9 7
`define UWF_B_T9 6
`define UWF_B_DIR 5
`define UWF_B_ORIE 3
`define UWF_B_NEIE 2
`define UWF_B_FEIE 1
`define UWF_B_PEIE 0
`define UWF_RST_C 8'h00
`define UWF_IDLE8 4'hA
`define UWF_IDLE9 4'hB
`endif

// file: design/uwf_pkg.sv
// types of the wakeup/flag block
package uwf_pkg;
    typedef struct packed {
        logic [8:0] data;
        logic noise;
        logic frame;
        logic parity;
    } uwf_rxc_t;
    typedef struct packed {
        logic tx_buffer_empty_flag;
        logic tc;
        logic rx_buffer_full_flag;
        logic idle;
        logic ovr;
        logic nf;
        logic fe;
        logic pf;
    } uwf_stat_t;
endpackage

// file: verification/tb_uwf_core.sv
// self-checking bench of the wakeup/flag core
`timescale 1ns/1ps
`include "uwf_params.svh"
module tb_uwf_core;
    import uwf_pkg::*;
    logic clk_sys_i, nrst_i, wr_i, rd_i, stop_i, stop_deep_i, rx_done_i;
    logic rx_msb_i, rx_bit_tick_i, rx_level_i, tx_load_i, tx_busy_i;
    logic tx_serial_i, rxd_i, txd_i, rx_serial_o, tx_req_o, txd_o, txd_oe_o;
    logic rxd_used_o, irq_tx_o, irq_rx_o, irq_err_o, go, msb, idle_go, run;
    logic [2:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic [8:0] tx_data_o;
    logic [4:0] idle_n;
    uwf_rxc_t rx_char_i, chr;
    int fail_count, n_tests, cyc;
    uwf_core uwf_core_i (.*);
    uwf_line_model uwf_line_model_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .go_i(go), .msb_i(msb), .chr_i(chr), .idle_go_i(idle_go),
        .idle_n_i(idle_n), .rx_done_o(rx_done_i), .rx_msb_o(rx_msb_i),
        .rx_char_o(rx_char_i), .rx_bit_tick_o(rx_bit_tick_i),
        .rx_level_o(rx_level_i));
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 chk({1'b0, rdata_o}, {1'b0, e});
    endtask
    // irq_tx, irq_rx, irq_err, rxd_used, txd_oe after they settle
    task automatic outs(input logic [4:0] e);
        repeat (3) @(posedge clk_sys_i);
        #1 chk({4'h0, irq_tx_o, irq_rx_o, irq_err_o, rxd_used_o, txd_oe_o},
            {4'h0, e});
    endtask
    task automatic send(input logic [11:0] c, input logic m);
        @(posedge clk_sys_i);
        chr <= c;
        msb <= m;
        go <= 1'b1;
        @(posedge clk_sys_i);
        go <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
    endtask
    task automatic idle(input logic [4:0] n);
        @(posedge clk_sys_i);
        idle_n <= n;
        idle_go <= 1'b1;
        @(posedge clk_sys_i);
        idle_go <= 1'b0;
        repeat (2 * n + 4) @(posedge clk_sys_i);
    endtask
    task automatic load();
        @(posedge clk_sys_i);
        tx_load_i <= 1'b1;
        @(posedge clk_sys_i);
        tx_load_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    // pins keep moving so the routing checks see real traffic
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (run) begin
            tx_serial_i <= ~tx_serial_i;
            txd_i <= cyc[1];
            rxd_i <= cyc[2];
        end
        if (cyc == 5000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        {nrst_i, wr_i, rd_i, stop_i, stop_deep_i, tx_load_i, tx_busy_i} = '0;
        {go, msb, idle_go, run, addr_i, wdata_i, idle_n, chr} = '0;
        {tx_serial_i, rxd_i, txd_i} = 3'h7;
        repeat (16) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        run <= 1'b1;
        rd(`UWF_A_S1, 8'hC0);
        send({9'h05A, 3'h0}, 1'b0);
        rd(`UWF_A_S1, 8'hE0);
        rd(`UWF_A_D, 8'h5A);
        rd(`UWF_A_S1, 8'hC0);
        send({9'h001, 3'h0}, 1'b0);
        send({9'h002, 3'h0}, 1'b0);
        rd(`UWF_A_S1, 8'hE8);
        rd(`UWF_A_D, 8'h01);
        rd(`UWF_A_S1, 8'hC0);
        $display("test receive and overrun done");
        wr(`UWF_A_C2, 8'h20);
        wr(`UWF_A_C3, 8'h0F);
        send({9'h00A, 3'h7}, 1'b0);
        send({9'h00B, 3'h0}, 1'b0);
        rd(`UWF_A_S1, 8'hE7);
        outs(5'b01111);
        rd(`UWF_A_D, 8'h0A);
        rd(`UWF_A_S1, 8'hC0);
        outs(5'b00011);
        wr(`UWF_A_C2, 8'h00);
        wr(`UWF_A_C3, 8'h00);
        $display("test error flags done");
        wr(`UWF_A_C1, 8'h08);
        wr(`UWF_A_C2, 8'h02);
        send({9'h011, 3'h0}, 1'b0);
        rd(`UWF_A_S1, 8'hC0);
        rd(`UWF_A_C2, 8'h02);
        send({9'h091, 3'h0}, 1'b1);
        rd(`UWF_A_S1, 8'hE0);
        rd(`UWF_A_D, 8'h91);
        rd(`UWF_A_C2, 8'h00);
        $display("test address wakeup done");
        wr(`UWF_A_C1, 8'h00);
        wr(`UWF_A_C2, 8'h02);
        idle(5'd9);
        rd(`UWF_A_C2, 8'h02);
        idle(5'd1);
        rd(`UWF_A_C2, 8'h00);
        rd(`UWF_A_S1, 8'hC0);
        send({9'h033, 3'h0}, 1'b0);
        rd(`UWF_A_S1, 8'hE0);
        rd(`UWF_A_D, 8'h33);
        idle(5'd10);
        rd(`UWF_A_S1, 8'hD0);
        rd(`UWF_A_D, 8'h33);
        idle(5'd10);
        rd(`UWF_A_S1, 8'hC0);
        $display("test idle line done");
        wr(`UWF_A_C1, 8'h10);
        send({9'h1A5, 3'h0}, 1'b1);
        rd(`UWF_A_S1, 8'hE0);
        rd(`UWF_A_D, 8'hA5);
        rd(`UWF_A_C3, 8'h80);
        rd(`UWF_A_S1, 8'hC0);
        wr(`UWF_A_C1, 8'h00);
        wr(`UWF_A_C3, 8'h40);
        wr(`UWF_A_D, 8'h3C);
        rd(`UWF_A_S1, 8'h00);
        load();
        chk(tx_data_o, 9'h13C);
        wr(`UWF_A_D, 8'h7E);
        load();
        chk(tx_data_o, 9'h17E);
        rd(`UWF_A_S1, 8'hC0);
        $display("test nine-bit data done");
        wr(`UWF_A_C2, 8'h80);
        outs(5'b10011);
        wr(`UWF_A_D, 8'h00);
        outs(5'b00011);
        @(posedge clk_sys_i);
        tx_busy_i <= 1'b1;
        load();
        wr(`UWF_A_C2, 8'h40);
        outs(5'b00011);
        @(posedge clk_sys_i);
        tx_busy_i <= 1'b0;
        outs(5'b10011);
        wr(`UWF_A_C2, 8'h00);
        $display("test transmit requests done");
        wr(`UWF_A_C1, 8'h80);
        outs(5'b00001);
        wr(`UWF_A_C1, 8'hA0);
        outs(5'b00000);
        wr(`UWF_A_C3, 8'h20);
        outs(5'b00001);
        wr(`UWF_A_C1, 8'h00);
        outs(5'b00011);
        $display("test routing done");
        @(posedge clk_sys_i);
        stop_i <= 1'b1;
        wr(`UWF_A_C1, 8'h80);
        stop_i <= 1'b0;
        rd(`UWF_A_C1, 8'h00);
        wr(`UWF_A_C1, 8'h80);
        stop_deep_i <= 1'b1;
        @(posedge clk_sys_i);
        stop_deep_i <= 1'b0;
        rd(`UWF_A_C1, 8'h00);
        outs(5'b00011);
        $display("test stop modes done");
        conclude();
    end
endmodule // tb_uwf_core

// file: verification/uwf_core_checker.sv
// port assertions of the wakeup/flag core
`timescale 1ns/1ps
module uwf_core_checker (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // inputs watched
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic stop_i,
    input wire logic stop_deep_i,
    input wire logic tx_load_i,
    input wire logic tx_serial_i,
    input wire logic rxd_i,
    input wire logic txd_i,
    // outputs watched
    input wire logic [7:0] rdata_o,
    input wire logic tx_req_o,
    input wire logic [8:0] tx_data_o,
    input wire logic rx_serial_o,
    input wire logic rxd_used_o,
    input wire logic txd_oe_o,
    input wire logic irq_tx_o,
    input wire logic irq_rx_o,
    input wire logic irq_err_o
);
    // the core keeps routing the line in stop and deep-stop cycles; these checks skip them anyway
    logic live_r;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            live_r <= 1'b1;
        end else begin
            live_r <= !stop_i && !stop_deep_i;
        end
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    property p_rd;
        rdata_o != 8'h00 |-> $past(rd_i);
    endproperty
    a_rd: assert property (p_rd) else $error("stray read data");
    property p_txirq;
        tx_req_o && $past(tx_req_o) |-> !irq_tx_o;
    endproperty
    a_txirq: assert property (p_txirq) else $error("tx irq while full");
    property p_load;
        tx_load_i && !wr_i && !stop_i && !stop_deep_i |-> ##2 !tx_req_o;
    endproperty
    a_load: assert property (p_load) else $error("load kept buffer full");
    property p_hold;
        !$past(tx_load_i) && !$past(stop_deep_i) |-> $stable(tx_data_o);
    endproperty
    a_hold: assert property (p_hold) else $error("tx data moved");
    property p_loop;
        live_r && !rxd_used_o && txd_oe_o |-> rx_serial_o == $past(tx_serial_i);
    endproperty
    a_loop: assert property (p_loop) else $error("loop route wrong");
    property p_wire_in;
        live_r && !rxd_used_o && !txd_oe_o |-> rx_serial_o == $past(txd_i);
    endproperty
    a_wire_in: assert property (p_wire_in) else $error("wire input wrong");
    property p_pin;
        live_r && rxd_used_o |-> rx_serial_o == $past(rxd_i);
    endproperty
    a_pin: assert property (p_pin) else $error("pin route wrong");
    property p_deep;
        // outputs trail the cleared registers by one more cycle
        $past(stop_deep_i, 2) |->
            !irq_tx_o && !irq_rx_o && !irq_err_o && rxd_used_o;
    endproperty
    a_deep: assert property (p_deep) else $error("deep stop kept state");
endmodule // uwf_core_checker
bind uwf_core uwf_core_checker uwf_core_checker_i (.*);

// file: verification/uwf_line_model.sv
// far-side receiver feed: start bit, msb mark, character done, idle bits
`timescale 1ns/1ps
module uwf_line_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // commands from the bench
    input wire logic go_i,
    input wire logic msb_i,
    input wire uwf_pkg::uwf_rxc_t chr_i,
    input wire logic idle_go_i,
    input wire logic [4:0] idle_n_i,
    // receiver shifter side
    output logic rx_done_o,
    output logic rx_msb_o,
    output uwf_pkg::uwf_rxc_t rx_char_o,
    output logic rx_bit_tick_o,
    output logic rx_level_o
);
    import uwf_pkg::*;
    logic [2:0] ph_r;
    logic [5:0] idle_r;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ph_r <= 3'h0;
            idle_r <= 6'h00;
            rx_done_o <= 1'b0;
            rx_msb_o <= 1'b0;
            rx_char_o <= '0;
            rx_bit_tick_o <= 1'b0;
            rx_level_o <= 1'b1;
        end else begin
            rx_done_o <= 1'b0;
            rx_msb_o <= 1'b0;
            rx_bit_tick_o <= 1'b0;
            // off its strobe nothing on these is valid, so keep them moving
            rx_char_o <= ~rx_char_o;
            rx_level_o <= ~rx_level_o;
            ph_r <= (go_i || ph_r != 3'h0) ? ph_r + 3'h1 : 3'h0;
            if (ph_r == 3'h1) begin
                rx_bit_tick_o <= 1'b1;
                rx_level_o <= 1'b0;
            end
            if (ph_r == 3'h3) rx_msb_o <= msb_i;
            if (ph_r == 3'h5) begin
                rx_done_o <= 1'b1;
                rx_char_o <= chr_i;
                ph_r <= 3'h0;
            end
            if (idle_go_i) begin
                idle_r <= {idle_n_i, 1'b0};
            end else if (idle_r != 6'h00) begin
                idle_r <= idle_r - 6'h01;
                if (idle_r[0]) begin
                    rx_bit_tick_o <= 1'b1;
                    rx_level_o <= 1'b1;
                end
            end
        end
    end
endmodule // uwf_line_model
